//--- rtl/dor_cfg.svh
// Register offsets, reset values and timing constants of the digital output router
`ifndef DOR_CFG_SVH
`define DOR_CFG_SVH
`define DOR_OFF_POLARITY   12'h008
`define DOR_OFF_MANUAL     12'h00c
`define DOR_OFF_FORCED     12'h010
`define DOR_OFF_APPLIED    12'h014
`define DOR_OFF_ROUTE_EN   12'h020
`define DOR_OFF_COMMAND    12'h040
`define DOR_OFF_FEEDBACK   12'h044
`define DOR_OFF_ROUTE0     12'h080
`define DOR_RST_WORD       32'h0000_0000
`define DOR_RST_ROUTE      16'h0000
`define DOR_SRC_LSB        8
`define DOR_SEL_INV_BIT    7
`define DOR_SEL_IDX_MSB    4
`define DOR_OUT_BASE_BIT   16
`define DOR_BRAKE_BIT      0
`define DOR_CLK_HZ         250000000
`define DOR_PWM_MAX_HZ     2000
`define DOR_PIN_MAX_HZ     500
`define DOR_PWM_MIN_CYC    ((`DOR_CLK_HZ + 2*`DOR_PWM_MAX_HZ - 1) / (2*`DOR_PWM_MAX_HZ))
`define DOR_PIN_MIN_CYC    ((`DOR_CLK_HZ + 2*`DOR_PIN_MAX_HZ - 1) / (2*`DOR_PIN_MAX_HZ))
`endif

//--- rtl/dor_pkg.sv
// Types shared by the digital output router
package dor_pkg;
    typedef enum logic [7:0] {
        DOR_SRC_ONE     = 8'h00,
        DOR_SRC_ZERO    = 8'h01,
        DOR_SRC_ENC_D1  = 8'h02,
        DOR_SRC_ENC_D64 = 8'h08,
        DOR_SRC_POS_D1  = 8'h09,
        DOR_SRC_POS_D64 = 8'h0f,
        DOR_SRC_PWM     = 8'h10,
        DOR_SRC_PWM_N   = 8'h11
    } dor_src_t;
    typedef struct packed {
        logic [15:0] src_sel;
        logic [7:0]  ctl_sel;
    } dor_route_t;
    typedef struct packed {
        logic enc_step;
        logic pos_step;
        logic brake_pwm;
        logic use_encoder;
    } dor_sig_t;
    typedef struct packed {
        logic [17:0] cnt;
        logic        lvl;
    } dor_limit_t;
endpackage

//--- rtl/dor_pulse_div.sv
// Divides increment pulses by 1..64 into a toggling square signal
`timescale 1ns/100ps
`default_nettype none
module dor_pulse_div
    import dor_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       step,
    output logic      [6:0] taps
);
    typedef struct packed {
        logic [5:0] cnt;
        logic       t1;
    } dor_div_t;
    dor_div_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        if (step) begin
            st_next.t1  = ~st_reg.t1;
            // t1 is the lowest counter bit, so cnt only carries above it
            st_next.cnt = st_reg.cnt + {5'h00, st_reg.t1};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // Divider 1 toggles each step, so every step shows as one edge
    assign taps = {st_reg.cnt, st_reg.t1};
endmodule
`default_nettype wire

//--- rtl/dor_rate_limit.sv
// Holds each level for a least number of cycles to bound output frequency
`timescale 1ns/100ps
`default_nettype none
module dor_rate_limit
    import dor_pkg::*;
#(
    // Wide enough for a 500 Hz hold at the full clock rate
    parameter logic [17:0] MIN_CYC = 18'h0_0001
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic din,
    output logic      dout
);
    dor_limit_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        if (st_reg.cnt != 18'h0_0000) begin
            st_next.cnt = st_reg.cnt - 18'h0_0001;
        end else if (din != st_reg.lvl) begin
            st_next.lvl = din;
            st_next.cnt = MIN_CYC - 18'h0_0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign dout = st_reg.lvl;
endmodule
`default_nettype wire

//--- rtl/dor_top.sv
// Digital output stage: polarity, manual override, routing and APB registers
//
// The placing of the registers and the APB register port were decided locally.
`include "dor_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Each mask bit affects only the output at the same position.
// - Polarity bit set makes command 1 drive the output low.
// - Manual bit set drives the output from forced mask, brake included.
// - Forced mask gives the level for each manually controlled output.
// - A readable copy of the applied output bits is kept.
// - Writing 1 to routing enable enters routing mode.
// - In routing mode polarity, manual and forced masks have no effect.
// - Route word is 16 bits: high byte source, low byte control bit.
// - Selected command bit gates the routed source onto the output.
// - Route word bit 7 inverts gating so command 0 enables.
// - Route word 0 is software PWM, words 1 to 4 outputs 1 to 4.
// - Source 00 is constant 1, source 01 constant 0.
// - Sources 02 to 08 give encoder steps divided by 1 to 64.
// - Sources 09 to 0F give position steps divided by 1 to 64.
// - Source 10 is brake PWM, source 11 its inverse.
// - Software PWM output up to 2 kHz, other outputs up to 500 Hz; only the routed slots are limited, not the brake or normal mode.
// - With divider 1 every single increment gives one pulse.
// - Encoder source produces pulses only with a real encoder.
// - Output n follows command bit 15+n; low 16 bits are special.
// - Command bit 0 controls the brake output.
module dor_top
    import dor_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire dor_sig_t    sig_in,
    input  wire logic [3:0]  out_pin_in,
    output logic      [3:0]  out_pin_out,
    output logic      [3:0]  out_pin_oe,
    output logic             brake_out,
    output logic             soft_pwm_out
);
    localparam int NRT = 5;
    typedef struct packed {
        logic [31:0]          polarity;
        logic [31:0]          manual;
        logic [31:0]          forced;
        logic [31:0]          applied;
        logic                 route_en;
        logic [31:0]          command;
        logic [NRT-1:0][15:0] route;
        logic [31:0]          rdata;
        logic                 err;
        logic                 ack;
    } dor_state_t;
    dor_state_t st_reg, st_next;

    logic      [6:0] enc_taps;
    logic      [6:0] pos_taps;
    wire logic [4:0] raw_lvl;
    wire logic [4:0] lim_lvl;

    // Extract one of seven divider taps from a 3-bit index (0 means divider 1)
    function automatic logic pick_tap(input logic [6:0] taps, input logic [2:0] idx);
        pick_tap = taps[idx];
    endfunction

    // Source mux shared by all five routed outputs
    function automatic logic route_src(input logic [7:0] src, input logic [6:0] et,
                                       input logic [6:0] pt, input logic pwm);
        logic v;
        v = 1'b0;
        if (src == DOR_SRC_ONE) begin
            v = 1'b1;
        end else if (src == DOR_SRC_ZERO) begin
            v = 1'b0;
        end else if (src >= DOR_SRC_ENC_D1 && src <= DOR_SRC_ENC_D64) begin
            v = pick_tap(et, 3'(src - DOR_SRC_ENC_D1));
        end else if (src >= DOR_SRC_POS_D1 && src <= DOR_SRC_POS_D64) begin
            v = pick_tap(pt, 3'(src - DOR_SRC_POS_D1));
        end else if (src == DOR_SRC_PWM) begin
            v = pwm;
        end else if (src == DOR_SRC_PWM_N) begin
            v = ~pwm;
        end
        route_src = v;
    endfunction

    // Gate by the selected command bit, optionally inverted
    function automatic logic route_gate(input logic [15:0] cfg, input logic [31:0] cmd);
        logic b;
        b = cmd[cfg[`DOR_SEL_IDX_MSB:0]];
        if (cfg[`DOR_SEL_INV_BIT]) begin
            b = ~b;
        end
        route_gate = b;
    endfunction

    // Encoder steps are suppressed on Hall feedback: Hall edges are too coarse
    dor_pulse_div u_enc_div (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (sig_in.enc_step & sig_in.use_encoder),
        .taps    (enc_taps)
    );
    dor_pulse_div u_pos_div (
        .pclk    (pclk),
        .presetn (presetn),
        .step    (sig_in.pos_step),
        .taps    (pos_taps)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NRT; gi++) begin : g_route
            assign raw_lvl[gi] = route_src(st_reg.route[gi][15:`DOR_SRC_LSB], enc_taps,
                                           pos_taps, sig_in.brake_pwm)
                                 & route_gate(st_reg.route[gi], st_reg.command);
            // Slot 0 is the software PWM with the faster limit
            dor_rate_limit #(
                .MIN_CYC (gi == 0 ? 18'(`DOR_PWM_MIN_CYC) : 18'(`DOR_PIN_MIN_CYC))
            ) u_lim (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (raw_lvl[gi]),
                .dout    (lim_lvl[gi])
            );
        end
    endgenerate

    logic [31:0] norm_bits;
    logic [31:0] route_bits;
    logic [31:0] next_applied;
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd;

    always_comb begin
        // Bitwise ops keep every mask bit local to its own output
        norm_bits = (st_reg.manual & st_reg.forced)
                  | (~st_reg.manual & (st_reg.command ^ st_reg.polarity));
        route_bits = '0;
        route_bits[`DOR_OUT_BASE_BIT +: 4] = lim_lvl[4:1];
        // Masks are ignored while routing, so the brake takes its command bit directly
        route_bits[`DOR_BRAKE_BIT] = st_reg.command[`DOR_BRAKE_BIT];
        next_applied = st_reg.route_en ? route_bits : norm_bits;
    end

    assign acc = psel & penable;
    // A write lands only at the completion edge, where pready is sampled high
    assign wr  = acc & pwrite & st_reg.ack;

    always_comb begin
        hit = 1'b1;
        rd  = 32'h0000_0000;
        unique case (paddr)
            `DOR_OFF_POLARITY: rd = st_reg.polarity;
            `DOR_OFF_MANUAL:   rd = st_reg.manual;
            `DOR_OFF_FORCED:   rd = st_reg.forced;
            `DOR_OFF_APPLIED:  rd = st_reg.applied;
            `DOR_OFF_ROUTE_EN: rd = {31'h0000_0000, st_reg.route_en};
            `DOR_OFF_COMMAND:  rd = st_reg.command;
            `DOR_OFF_FEEDBACK: rd = {28'h000_0000, out_pin_in};
            default: begin
                hit = 1'b0;
                for (int ri = 0; ri < NRT; ri++) begin
                    if (paddr == 12'(`DOR_OFF_ROUTE0 + 4 * ri)) begin
                        hit = 1'b1;
                        rd  = {16'h0000, st_reg.route[ri]};
                    end
                end
            end
        endcase
    end

    always_comb begin
        st_next = st_reg;
        st_next.applied = next_applied;
        st_next.ack     = acc & ~st_reg.ack;
        if (acc) begin
            st_next.err   = ~hit;
            st_next.rdata = (hit && !pwrite) ? rd : 32'h0000_0000;
        end
        if (wr && hit) begin
            unique case (paddr)
                `DOR_OFF_POLARITY: st_next.polarity = pwdata;
                `DOR_OFF_MANUAL:   st_next.manual   = pwdata;
                `DOR_OFF_FORCED:   st_next.forced   = pwdata;
                `DOR_OFF_ROUTE_EN: st_next.route_en = pwdata[0];
                `DOR_OFF_COMMAND:  st_next.command  = pwdata;
                default: begin
                    for (int ri = 0; ri < NRT; ri++) begin
                        if (paddr == 12'(`DOR_OFF_ROUTE0 + 4 * ri)) begin
                            st_next.route[ri] = pwdata[15:0];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // One wait state: data and error are registered at the access edge
    assign pready  = st_reg.ack;
    assign prdata  = st_reg.rdata;
    assign pslverr = st_reg.ack & st_reg.err;

    // Open drain: a high level releases the pin, a low level pulls it down
    assign out_pin_out  = 4'h0;
    assign out_pin_oe   = ~st_reg.applied[`DOR_OUT_BASE_BIT +: 4];
    assign brake_out    = st_reg.applied[`DOR_BRAKE_BIT];
    assign soft_pwm_out = st_reg.route_en & lim_lvl[0];
endmodule
`default_nettype wire

//--- verif/dor_props.sv
// Concurrent checks on the ports of the digital output router
`include "dor_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dor_props
    import dor_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire dor_sig_t    sig_in,
    input wire logic [3:0]  out_pin_in,
    input wire logic [3:0]  out_pin_out,
    input wire logic [3:0]  out_pin_oe,
    input wire logic        brake_out,
    input wire logic        soft_pwm_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_rd(logic [11:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    wait_one_a: assert property (s_wait |=> pready) else $error("no answer after one wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    err_hole_a: assert property (pready && paddr == 12'h0fc |-> pslverr) else $error("hole ok");
    err_none_a: assert property (s_rd(`DOR_OFF_FORCED) |-> !pslverr) else $error("bad error");
    drive_low_a: assert property (out_pin_out == 4'h0) else $error("pin driven high");
    // Read data is captured one edge before pready, so compare with the prior cycle
    applied_pins_a: assert property (s_rd(`DOR_OFF_APPLIED) |->
        prdata[19:16] == ~$past(out_pin_oe) && prdata[0] == $past(brake_out))
        else $error("copy differs");
    pin_back_a: assert property (s_rd(`DOR_OFF_FEEDBACK) |-> prdata[3:0] == $past(out_pin_in))
        else $error("pin readback differs");
    route_word_a: assert property (s_rd(`DOR_OFF_ROUTE0) |-> prdata[31:16] == 16'h0000)
        else $error("route word too wide");
endmodule
bind dor_top dor_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sig_in(sig_in), .out_pin_in(out_pin_in), .out_pin_out(out_pin_out),
    .out_pin_oe(out_pin_oe), .brake_out(brake_out), .soft_pwm_out(soft_pwm_out));
`default_nettype wire

//--- verif/dor_loads.sv
// Open-drain loads with pull-ups on the four output pins
`timescale 1ns/100ps
`default_nettype none
module dor_loads (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_lvl
);
    // A released pin is pulled up, a driven one follows the driver
    assign pin_lvl = (pin_oe & pin_out) | ~pin_oe;
endmodule
`default_nettype wire

//--- verif/dor_top_bench.sv
// Self-checking testbench of the digital output router
`include "dor_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dor_top_bench
    import dor_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  pin_lvl;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic        brake_out;
    logic        soft_pwm_out;
    logic [31:0] rd;
    logic        er;
    logic [31:0] e;
    dor_sig_t    sig = '0;
    int          fails = 0;
    int          n_checks = 0;
    dor_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sig_in(sig), .out_pin_in(pin_lvl), .out_pin_out(pin_out),
        .out_pin_oe(pin_oe), .brake_out(brake_out), .soft_pwm_out(soft_pwm_out));
    dor_loads load_u (.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));
    initial forever #2 pclk = ~pclk;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Called just after a rising edge; holds the request until pready is seen
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset();
        logic [11:0] regs[6];
        regs = '{`DOR_OFF_POLARITY, `DOR_OFF_MANUAL, `DOR_OFF_FORCED, `DOR_OFF_APPLIED,
                 `DOR_OFF_ROUTE_EN, `DOR_OFF_ROUTE0};
        check("oe", {28'h0, pin_oe}, 32'hf);
        check("brake", {31'h0, brake_out}, 32'h0);
        check("pwm", {31'h0, soft_pwm_out}, 32'h0);
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            check("reset value", rd, `DOR_RST_WORD);
        end
    endtask
    // Normal mode over a table of command and mask settings
    task automatic t_normal();
        logic [31:0] cmd[4] = '{32'h000a_0001, 32'h000a_0001, 32'h0000_0000, 32'h0005_0001};
        logic [31:0] pol[4] = '{32'h0, 32'h0002_0001, 32'h0, 32'hfff0_fffe};
        logic [31:0] man[4] = '{32'h0, 32'h0, 32'h0004_0001, 32'hfff0_fffe};
        logic [31:0] frc[4] = '{32'h0, 32'h0, 32'h0000_0001, 32'h0};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `DOR_OFF_POLARITY, pol[i]);
            apb(1'b1, `DOR_OFF_MANUAL, man[i]);
            apb(1'b1, `DOR_OFF_FORCED, frc[i]);
            apb(1'b1, `DOR_OFF_COMMAND, cmd[i]);
            repeat (4) @(posedge pclk);
            e = (man[i] & frc[i]) | (~man[i] & (cmd[i] ^ pol[i]));
            check("oe", {28'h0, pin_oe}, {28'h0, ~e[19:16]});
            check("brake", {31'h0, brake_out}, {31'h0, e[0]});
            apb(1'b0, `DOR_OFF_APPLIED, 32'h0);
            check("applied", rd & 32'h000f_0001, e & 32'h000f_0001);
            apb(1'b0, `DOR_OFF_FEEDBACK, 32'h0);
            check("pins", rd & 32'hf, {28'h0, e[19:16]});
        end
    endtask
    task automatic t_refuse();
        apb(1'b1, 12'h0fc, 32'hffff_ffff);
        check("hole write err", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h0fc, 32'h0);
        check("hole read", {er, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, `DOR_OFF_APPLIED, 32'hffff_ffff);
        apb(1'b0, `DOR_OFF_APPLIED, 32'h0);
        check("applied ro", rd & 32'h000f_0001, e & 32'h000f_0001);
        check("ro no err", {31'h0, er}, 32'h0);
    endtask
    // Reset first: each limiter may then make one immediate change, later ones are held long
    task automatic t_route();
        logic [15:0] cfg[5] = '{16'h1186, 16'h0005, 16'h0205, 16'h0a05, 16'h0085};
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("oe after reset", {28'h0, pin_oe}, 32'hf);
        check("brake after reset", {31'h0, brake_out}, 32'h0);
        // Command first with only bit 5 set and brake bit clear, so slots 0 to 3 are gated on as their words land
        apb(1'b1, `DOR_OFF_COMMAND, 32'h0000_0020);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, `DOR_OFF_ROUTE0 + 12'(4 * i), {16'h5a5a, cfg[i]});
            apb(1'b0, `DOR_OFF_ROUTE0 + 12'(4 * i), 32'h0);
            check("route word", rd, {16'h0000, cfg[i]});
        end
        apb(1'b1, `DOR_OFF_MANUAL, 32'hffff_ffff);
        apb(1'b1, `DOR_OFF_FORCED, 32'hffff_ffff);
        apb(1'b1, `DOR_OFF_ROUTE_EN, 32'h1);
        apb(1'b0, `DOR_OFF_ROUTE_EN, 32'h0);
        check("route enable", rd & 32'h1, 32'h1);
        repeat (4) @(posedge pclk);
        check("routed oe", {28'h0, pin_oe}, 32'he);
        check("routed brake", {31'h0, brake_out}, 32'h0);
        check("soft pwm", {31'h0, soft_pwm_out}, 32'h1);
        sig.enc_step <= 1'b1;
        sig.pos_step <= 1'b1;
        @(posedge pclk);
        sig.enc_step <= 1'b0;
        sig.pos_step <= 1'b0;
        repeat (4) @(posedge pclk);
        check("hall and half step", {28'h0, pin_oe}, 32'he);
        sig.use_encoder <= 1'b1;
        sig.enc_step <= 1'b1;
        sig.pos_step <= 1'b1;
        @(posedge pclk);
        sig.enc_step <= 1'b0;
        sig.pos_step <= 1'b0;
        repeat (4) @(posedge pclk);
        check("step pulses", {28'h0, pin_oe}, 32'h8);
        apb(1'b0, `DOR_OFF_FEEDBACK, 32'h0);
        check("routed pins", rd & 32'hf, 32'h7);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_normal();
        t_refuse();
        t_route();
        wrap_up();
    end
endmodule
`default_nettype wire
